// [core/fes_pkg.sv]
// package for the flash erase sequencer (host side)
// assumes a parallel flash whose bus cycles the controller paces itself
package fes_pkg;
  // flash command bytes
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_BLOCK_SETUP = 8'h20;
  localparam logic [7:0] CMD_CHIP_SETUP = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  // status byte bit positions
  localparam int BIT_READY = 7;
  localparam int BIT_ERASE_ERR = 5;
  localparam int BIT_WRITE_ERR = 4;
  localparam int BIT_SUPPLY_ERR = 3;
  localparam int BIT_PROTECT_ERR = 1;
  // host-side register offsets (word index on the software port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_RESULT = 4'h3;
  // control register field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_CHIP = 1;
  localparam int CTRL_CHECK = 2;
  localparam int CTRL_CLEAR = 3;
  localparam int CTRL_FINISH = 4;
  // bus cycle timing: clock period and strobe width in ns, at 100 MHz
  localparam int CLK_NS = 10;
  localparam int STROBE_NS = 70;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // result codes of the full status check
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_SUPPLY = 3'h1;
  localparam logic [2:0] RES_PROTECT = 3'h2;
  localparam logic [2:0] RES_SEQUENCE = 3'h3;
  localparam logic [2:0] RES_ERASE = 3'h4;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_PRE_CMD = 4'b0001,
    ST_PRE_POLL = 4'b0010,
    ST_SETUP = 4'b0011,
    ST_CONFIRM = 4'b0100,
    ST_POST_POLL = 4'b0101,
    ST_CHECK_CMD = 4'b0110,
    ST_CHECK_RD = 4'b0111,
    ST_CLEAR = 4'b1000,
    ST_FINISH = 4'b1001
  } fes_state_t;
endpackage : fes_pkg

// [core/fes_host.sv]
// host controller that drives block and full-chip erase on a parallel flash
// assumes flash data sampled synchronously to ref_clk; software port below
//
// What this block does
// - block erase writes 20H then D0H addressed inside the target block
// - further blocks erased one at a time after ready is reported
// - full status check runs per erase or once after a series
// - read-array FFH written after the last erase
// - any found error leads to clear-status before retry
// - check supply, then protect, then write+erase together, then erase alone
// - full-chip erase writes 30H then D0H; erase flag means chip erase failed
// - full-chip erase status check may also be deferred
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module fes_host
  import fes_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic [19:0] flashAddr,
  output logic [7:0] flashDout,
  output logic flashDoutEn,
  input wire logic [7:0] flashDin,
  output logic flashChipEn_n,
  output logic flashWriteEn_n,
  output logic flashOutEn_n
);

  // ****************************************
  // state and registers
  // ****************************************
  fes_state_t state_r;
  logic [19:0] target_r;
  logic chip_r;
  logic check_r;
  logic finish_r;
  logic busy_r;
  logic done_r;
  logic [7:0] status_r;
  logic [2:0] result_r;
  logic [3:0] cnt_r;
  logic [7:0] wrByte;
  logic cycleDone;
  logic isWriteCycle;
  logic startReq;

  // a request is only accepted while idle, so erases never overlap
  assign startReq = regWrite && regAddr == REG_CTRL && !busy_r;
  assign cycleDone = cnt_r == STROBE_CNT;

  // writing states and the byte each puts on the bus
  function automatic logic [7:0] cmd_of(input fes_state_t s, input logic chip);
    case (s)
      ST_PRE_CMD: cmd_of = CMD_READ_STATUS;
      ST_CHECK_CMD: cmd_of = CMD_READ_STATUS;
      ST_SETUP: cmd_of = chip ? CMD_CHIP_SETUP : CMD_BLOCK_SETUP;
      ST_CONFIRM: cmd_of = CMD_CONFIRM;
      ST_CLEAR: cmd_of = CMD_CLEAR_STATUS;
      ST_FINISH: cmd_of = CMD_READ_ARRAY;
      default: cmd_of = BYTE_RESET;
    endcase
  endfunction : cmd_of

  assign wrByte = cmd_of(state_r, chip_r);
  assign isWriteCycle = state_r != ST_IDLE && state_r != ST_PRE_POLL && state_r != ST_POST_POLL
    && state_r != ST_CHECK_RD;

  // ****************************************
  // software port
  // ****************************************
  // control fields latched at start; bits read back in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      target_r <= '0;
      chip_r <= 1'b0;
      check_r <= 1'b0;
      finish_r <= 1'b0;
    end
    else if (regWrite && regAddr == REG_ADDR && !busy_r)
      target_r <= regWdata[19:0];
    else if (startReq)
    begin
      chip_r <= regWdata[CTRL_CHIP];
      check_r <= regWdata[CTRL_CHECK];
      finish_r <= regWdata[CTRL_FINISH];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      regRdata <= '0;
    else if (regRead)
      case (regAddr)
        REG_CTRL: regRdata <= {27'h0000000, finish_r, 1'b0, check_r, chip_r, 1'b0};
        REG_ADDR: regRdata <= {12'h000, target_r};
        REG_STATUS: regRdata <= {22'h000000, done_r, busy_r, status_r};
        REG_RESULT: regRdata <= {29'h00000000, result_r};
        default: regRdata <= '0;
      endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  // each bus cycle: strobe low for STROBE_CNT clocks, then one recovery clock
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      cnt_r <= CNT_RESET;
    else if (state_r == ST_IDLE || cycleDone)
      cnt_r <= CNT_RESET;
    else
      cnt_r <= cnt_r + 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      status_r <= BYTE_RESET;
      result_r <= RES_OK;
    end
    else
      case (state_r)
        ST_IDLE:
        begin
          if (startReq && regWdata[CTRL_CLEAR])
          begin
            state_r <= ST_CLEAR;
            busy_r <= 1'b1;
            done_r <= 1'b0;
          end
          else if (startReq && regWdata[CTRL_START])
          begin
            state_r <= ST_PRE_CMD;
            busy_r <= 1'b1;
            done_r <= 1'b0;
          end
        end
        ST_PRE_CMD: if (cycleDone) state_r <= ST_PRE_POLL;
        ST_PRE_POLL:
          if (cycleDone)
          begin
            status_r <= flashDin;
            if (flashDin[BIT_READY]) state_r <= ST_SETUP;
          end
        ST_SETUP: if (cycleDone) state_r <= ST_CONFIRM;
        ST_CONFIRM: if (cycleDone) state_r <= ST_POST_POLL;
        ST_POST_POLL:
          if (cycleDone)
          begin
            status_r <= flashDin;
            if (flashDin[BIT_READY])
              state_r <= check_r ? ST_CHECK_CMD : (finish_r ? ST_FINISH : ST_IDLE);
            if (flashDin[BIT_READY] && !check_r && !finish_r)
            begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        ST_CHECK_CMD: if (cycleDone) state_r <= ST_CHECK_RD;
        ST_CHECK_RD:
          if (cycleDone)
          begin
            status_r <= flashDin;
            // supply first, then protect, then both write and erase, then erase alone
            if (flashDin[BIT_SUPPLY_ERR]) result_r <= RES_SUPPLY;
            else if (flashDin[BIT_PROTECT_ERR]) result_r <= RES_PROTECT;
            else if (flashDin[BIT_WRITE_ERR] && flashDin[BIT_ERASE_ERR]) result_r <= RES_SEQUENCE;
            else if (flashDin[BIT_ERASE_ERR]) result_r <= RES_ERASE;
            else result_r <= RES_OK;
            // flags are sticky in the device, so the check sees every erase since last clear
            if (finish_r) state_r <= ST_FINISH;
            else
            begin
              state_r <= ST_IDLE;
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        ST_CLEAR:
          if (cycleDone)
          begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
            result_r <= RES_OK;
          end
        ST_FINISH:
          if (cycleDone)
          begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
        default: state_r <= ST_IDLE;
      endcase
  end

  // ****************************************
  // flash pins
  // ****************************************
  // strobes drop for the active part of each cycle; write enable rises one clock early for data hold, the others in the last clock
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      flashChipEn_n <= 1'b1;
      flashWriteEn_n <= 1'b1;
      flashOutEn_n <= 1'b1;
      flashDoutEn <= 1'b0;
      flashDout <= BYTE_RESET;
      flashAddr <= '0;
    end
    else
    begin
      flashChipEn_n <= state_r == ST_IDLE || cycleDone;
      flashWriteEn_n <= !isWriteCycle || cycleDone || cnt_r == STROBE_CNT - 4'h1;
      flashOutEn_n <= isWriteCycle || state_r == ST_IDLE || cycleDone;
      flashDoutEn <= isWriteCycle && !cycleDone;
      flashDout <= wrByte;
      // confirm goes to the target block; other cycles may use any address
      flashAddr <= (state_r == ST_CONFIRM && !chip_r) ? target_r : 20'h00000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_confirm_byte: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_r == ST_CONFIRM && !flashWriteEn_n |-> flashDout == CMD_CONFIRM)
    else $error("confirm cycle drove wrong byte");
  a_setup_byte: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(state_r == ST_CONFIRM) |-> $past(state_r) == ST_SETUP)
    else $error("confirm without setup");
  a_confirm_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_r == ST_CONFIRM && cnt_r != CNT_RESET && !chip_r |-> flashAddr == target_r)
    else $error("confirm not in target block");
  a_one_erase: assert property (@(posedge ref_clk) disable iff (!reset_n)
    busy_r && regWrite && regAddr == REG_CTRL |=> state_r != ST_PRE_CMD || $past(state_r) == ST_PRE_CMD)
    else $error("erase started while busy");
  a_ready_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_r == ST_PRE_POLL && cycleDone && !flashDin[BIT_READY] |=> state_r == ST_PRE_POLL)
    else $error("setup issued while busy");
  a_check_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_r == ST_CHECK_RD && cycleDone && flashDin[BIT_SUPPLY_ERR] |=> result_r == RES_SUPPLY)
    else $error("supply error not ranked first");
  a_sequence_err: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_r == ST_CHECK_RD && cycleDone && flashDin[5:3] == 3'b110 && !flashDin[BIT_PROTECT_ERR]
    |=> result_r == RES_SEQUENCE)
    else $error("sequence error misread");
  a_finish_array: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_r == ST_FINISH && cycleDone |-> flashDout == CMD_READ_ARRAY ##1 state_r == ST_IDLE)
    else $error("read array not issued");
  // the engine stays busy for dozens of clocks, so the window must outlast several polls
  c_block: cover property (@(posedge ref_clk) state_r == ST_CONFIRM && !chip_r ##[1:200] state_r == ST_IDLE);
  c_pre_wait: cover property (@(posedge ref_clk) state_r == ST_PRE_POLL && cycleDone && !flashDin[BIT_READY]);
  c_chip: cover property (@(posedge ref_clk) state_r == ST_CONFIRM && chip_r);
  c_error: cover property (@(posedge ref_clk) result_r == RES_ERASE);

endmodule : fes_host

// [verif/fes_flash_model.sv]
// behavioural parallel flash that answers status, erase and read-array commands
// assumes the host paces its strobes on ref_clk, as the sequencer does
`timescale 1ns/1ps
module fes_flash_model
  import fes_pkg::*;
#(
  parameter int BUSY_CYC = 40,
  parameter logic [7:0] ARRAY_BYTE = 8'hA5
)
(
  input wire logic ref_clk,
  input wire logic [19:0] flashAddr,
  input wire logic [7:0] flashDout,
  input wire logic flashChipEn_n,
  input wire logic flashWriteEn_n,
  input wire logic flashOutEn_n,
  input wire logic [1:0] failMode,
  input wire logic allLocked,
  output logic [7:0] flashDin,
  output logic [3:0] erasedBlk,
  output logic [3:0] chipCount,
  output logic arrayMode
);
  // ************************************************************
  // command decode and erase engine
  // ************************************************************
  logic weP_r = 1'b1;
  logic arr_r = 1'b0;
  logic [7:0] cmd_r = 8'h00;
  logic [7:0] setup_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic [5:0] err_r = 6'h00;
  logic [19:0] adr_r = 20'h00000;
  logic [3:0] blk_r = 4'h0;
  logic [3:0] chip_r = 4'h0;
  // engine starts busy so the first poll before a sequence has to wait
  int busy_r = BUSY_CYC;
  logic drive;
  logic chipLock;
  assign chipLock = (setup_r == CMD_CHIP_SETUP) && allLocked;
  // a command is taken at the rising edge of the write strobe
  always @(posedge ref_clk)
  begin
    weP_r <= flashWriteEn_n;
    if (busy_r > 0)
      busy_r <= busy_r - 1;
    if (!flashWriteEn_n)
    begin
      cmd_r <= flashDout;
      adr_r <= flashAddr;
    end
    if (flashWriteEn_n && !weP_r && !flashChipEn_n)
    begin
      setup_r <= 8'h00;
      arr_r <= (cmd_r == CMD_READ_ARRAY);
      if (cmd_r == CMD_CLEAR_STATUS)
        err_r <= 6'h00;
      else if (cmd_r == CMD_CONFIRM && setup_r != 8'h00)
      begin
        busy_r <= BUSY_CYC;
        // flags only accumulate until cleared
        err_r <= err_r | {failMode[0] ^ failMode[1], failMode == 2'd2, failMode == 2'd3, 1'b0, chipLock, 1'b0};
        if (failMode == 2'd0 && !chipLock && setup_r == CMD_CHIP_SETUP)
          chip_r <= chip_r + 4'h1;
        else if (failMode == 2'd0 && !chipLock)
          blk_r <= adr_r[19:16];
      end
      else if (cmd_r == CMD_CONFIRM)
        err_r[5:4] <= 2'b11;
      else if (cmd_r == CMD_BLOCK_SETUP || cmd_r == CMD_CHIP_SETUP)
        setup_r <= cmd_r;
    end
  end
  // released data lines show the inverse of the last byte, not a stale copy
  assign drive = !flashChipEn_n && !flashOutEn_n;
  assign flashDin = drive ? (arr_r ? ARRAY_BYTE : {busy_r == 0, 1'b0, err_r}) : ~last_r;
  always @(posedge ref_clk)
    if (drive)
      last_r <= flashDin;
  assign erasedBlk = blk_r;
  assign chipCount = chip_r;
  assign arrayMode = arr_r;
endmodule : fes_flash_model

// [verif/tb.sv]
// self-checking bench for the erase sequencer against a flash model
// assumes the software port and flash pins as declared by fes_host
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errCount++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb
  import fes_pkg::*;
;
  // ************************************************************
  // signals, design and flash model
  // ************************************************************
  logic ref_clk, reset_n, regWrite, regRead, flashDoutEn, ce_n, we_n, oe_n, allLocked, arrayMode;
  logic [3:0] regAddr, erasedBlk, chipCount;
  logic [31:0] regWdata, regRdata, rd;
  logic [19:0] flashAddr;
  logic [7:0] flashDout, flashDin;
  logic [1:0] failMode;
  int errCount = 0;
  int checks = 0;
  int pinErr = 0;
  // ctrl byte, failure mode, all-locked, expected result
  logic [13:0] tc [5] = '{{8'h05, 2'd1, 1'b0, 3'h4}, {8'h07, 2'd0, 1'b1, 3'h2},
    {8'h07, 2'd3, 1'b1, 3'h1}, {8'h05, 2'd2, 1'b0, 3'h3}, {8'h07, 2'd0, 1'b0, 3'h0}};
  fes_host dut (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .flashAddr(flashAddr),
    .flashDout(flashDout), .flashDoutEn(flashDoutEn), .flashDin(flashDin), .flashChipEn_n(ce_n),
    .flashWriteEn_n(we_n), .flashOutEn_n(oe_n));
  fes_flash_model flash (.ref_clk(ref_clk), .flashAddr(flashAddr), .flashDout(flashDout),
    .flashChipEn_n(ce_n), .flashWriteEn_n(we_n), .flashOutEn_n(oe_n), .failMode(failMode),
    .allLocked(allLocked), .flashDin(flashDin), .erasedBlk(erasedBlk), .chipCount(chipCount),
    .arrayMode(arrayMode));
  // data drive must cover every write strobe and never meet an output enable
  always @(negedge ref_clk)
    if (reset_n && ((!we_n && !flashDoutEn) || (!oe_n && flashDoutEn)))
      pinErr++;
  // ************************************************************
  // software port tasks
  // ************************************************************
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : reg_rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // poll busy after a start; a hung sequencer ends the run
  task automatic wait_idle();
    int n;
    for (n = 0; n < 3000; n++)
    begin
      reg_rd(REG_STATUS, rd);
      if (rd[8] === 1'b0)
        break;
    end
    if (n == 3000)
    begin
      errCount++;
      print_verdict();
    end
  endtask : wait_idle
  task automatic run_op(input logic [31:0] c);
    reg_wr(REG_CTRL, c);
    wait_idle();
  endtask : run_op
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ************************************************************
  // test sequence
  // ************************************************************
  initial
  begin
    {reset_n, regWrite, regRead, allLocked, failMode, regAddr, regWdata} = '0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    // plain block erase, full check, then back to array reads
    reg_wr(REG_ADDR, 32'h0003_1234);
    run_op(32'h0000_0015);
    reg_rd(REG_STATUS, rd);
    `CHK(rd[9:7], 3'b101)
    reg_rd(REG_RESULT, rd);
    `CHK(rd[2:0], RES_OK)
    `CHK(erasedBlk, 4'h3)
    `CHK(arrayMode, 1'b1)
    $display("block erase test done");
    // every failure kind, each followed by a clear before the next try
    foreach (tc[i])
    begin
      failMode <= tc[i][5:4];
      allLocked <= tc[i][3];
      run_op({24'h0, tc[i][13:6]});
      reg_rd(REG_RESULT, rd);
      `CHK(rd[2:0], tc[i][2:0])
      run_op(32'h0000_0008);
    end
    `CHK(chipCount, 4'h1)
    $display("failure table test done");
    // a failed erase left unchecked must still show after a later good erase
    failMode <= 2'd1;
    allLocked <= 1'b0;
    run_op(32'h0000_0001);
    failMode <= 2'd0;
    reg_wr(REG_ADDR, 32'h0005_0000);
    run_op(32'h0000_0005);
    reg_rd(REG_RESULT, rd);
    `CHK(rd[2:0], RES_ERASE)
    `CHK(erasedBlk, 4'h5)
    run_op(32'h0000_0008);
    // orders written while busy are refused, so the erase stays on block 5
    reg_wr(REG_CTRL, 32'h0000_0005);
    reg_wr(REG_ADDR, 32'h0009_0000);
    reg_wr(REG_CTRL, 32'h0000_0003);
    wait_idle();
    `CHK(erasedBlk, 4'h5)
    `CHK(chipCount, 4'h1)
    reg_rd(REG_ADDR, rd);
    `CHK(rd, 32'h0005_0000)
    reg_rd(REG_RESULT, rd);
    `CHK(rd[2:0], RES_OK)
    reg_rd(4'h9, rd);
    `CHK(rd, 32'h0000_0000)
    `CHK(pinErr, 0)
    $display("sticky error test done");
    print_verdict();
  end
endmodule : tb
